// ### rtl/afpm_pkg.sv
/*
 Pin mux constants: field codes, bit positions, reset values.
 Assumes one system clock.
*/
package afpm_pkg;
  // ----------------------------------------------------------------
  // Function field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_ANALOG = 4'h0;
  localparam logic [3:0] FN_OUT_PP = 4'h1;
  localparam logic [3:0] FN_IN = 4'h4;
  localparam logic [3:0] FN_ALT_PP = 4'h9;
  localparam logic [3:0] FN_ALT_OD = 4'hD;
  localparam logic [15:0] CFG_RESET = 16'h4444;
  // ----------------------------------------------------------------
  // Field positions (low bit of each 4-bit field)
  // ----------------------------------------------------------------
  localparam int F0 = 0;
  localparam int F1 = 4;
  localparam int F2 = 8;
  localparam int F3 = 12;
  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int REMAP_CH1 = 4;
  localparam int REMAP_CH2 = 5;
  localparam int REMAP_CH3 = 6;
  localparam int REMAP_CH4 = 7;
  localparam int DBG_REG_DISABLE = 4;
  localparam int SPI_MASTER = 4;
  localparam int UART_FLOW = 5;
  localparam logic [7:0] REMAP_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Serial controller modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AFPM_SC_OFF = 2'h0,
    AFPM_SC_UART = 2'h1,
    AFPM_SC_SPI = 2'h2,
    AFPM_SC_I2C = 2'h3
  } afpm_sc_mode_t;
  // Config write bus
  typedef struct packed {
    logic wr;
    logic privileged;
    logic [2:0] sel;
    logic [15:0] data;
  } afpm_cfg_wr_t;
  localparam logic [2:0] SEL_PA_LO = 3'h0;
  localparam logic [2:0] SEL_PA_HI = 3'h1;
  localparam logic [2:0] SEL_PB_LO = 3'h2;
  localparam logic [2:0] SEL_PB_HI = 3'h3;
  localparam logic [2:0] SEL_PC_HI = 3'h4;
  localparam logic [2:0] SEL_DBG = 3'h5;
  localparam logic [2:0] SEL_REMAP = 3'h6;
endpackage : afpm_pkg

// ### rtl/afpm_top.sv
/*
 Alternate function pin mux for twelve shared pads.
 Assumes peripherals on clk_in and pads outside,
 pad enables low while the mux drives a pin.
*/
`timescale 1ns/100ps
module afpm_top #(
  parameter int STRAP_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire afpm_pkg::afpm_cfg_wr_t cfg_wr_in,
  input wire logic [2:0] cfg_rd_sel_in,
  output logic [15:0] cfg_rd_data_out,
  output logic cfg_refused_out,
  input wire logic [3:0] timer2_channel_output_enables_in,
  input wire logic timer1_channel_output_enables_in,
  input wire logic [3:0] timer2_out_in,
  output logic [3:0] timer2_cap_out,
  input wire logic timer1_channel_four_in,
  output logic timer1_channel_four_cap_out,
  input wire afpm_pkg::afpm_sc_mode_t serial1_function_select_in,
  input wire afpm_pkg::afpm_sc_mode_t serial2_function_select_in,
  input wire logic [7:0] serial1_spi_config_in,
  input wire logic [7:0] serial2_spi_config_in,
  input wire logic [7:0] serial1_uart_config_in,
  input wire logic serial1_spi_clock_in,
  output logic serial1_spi_clock_out,
  output logic serial1_slave_select_out,
  input wire logic serial1_rts_in,
  output logic serial1_cts_out,
  input wire logic serial2_master_out_slave_in_in,
  input wire logic serial2_master_in_slave_out_in,
  input wire logic serial2_spi_clock_in,
  input wire logic serial2_i2c_data_in,
  input wire logic serial2_i2c_clock_in,
  output logic serial2_data_rx_out,
  output logic serial2_spi_clock_out,
  output logic serial2_slave_select_out,
  output logic serial2_i2c_data_out,
  output logic serial2_i2c_clock_out,
  input wire logic radio_tx_mode_in,
  input wire logic reg_enable_in,
  input wire logic packet_trace_frame_in,
  input wire logic packet_trace_serial_data_in,
  input wire logic trace_enable_in,
  input wire logic trace_four_wire_in,
  input wire logic cpu_trace_clock_in,
  input wire logic cpu_trace_bit_two_in,
  input wire logic cpu_trace_bit_three_in,
  input wire logic [11:0] gpio_data_in,
  input wire logic [11:0] gpio_dir_in,
  output logic [11:0] gpio_read_out,
  output logic bootloader_strap_n_out,
  output logic lowfreq_digital_clock_out,
  output logic lowfreq_crystal_a_out,
  output logic lowfreq_crystal_b_out,
  output logic analog_input_four_out,
  output logic analog_input_five_out,
  input wire logic [11:0] pad_in,
  output logic [11:0] pad_out,
  output logic [11:0] pad_oe_n_out
);
  // Pad index: 0-5 PA0-5, 6 PA7, 7-8 PB3-4, 9-11 PC5-7
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] fld(input logic [15:0] r, input int pos);
    fld = r[pos +: 4];
  endfunction : fld
  function automatic logic is_alt(input logic [3:0] f);
    is_alt = (f == afpm_pkg::FN_ALT_PP) || (f == afpm_pkg::FN_ALT_OD);
  endfunction : is_alt
  function automatic logic is_ana(input logic [3:0] f);
    is_ana = (f == afpm_pkg::FN_ANALOG);
  endfunction : is_ana

  logic [15:0] pa_lo_q, pa_hi_q, pb_lo_q, pb_hi_q, pc_hi_q;
  logic [7:0] dbg_q, remap_q;
  logic [11:0] pad_s1_q, pad_s2_q;
  logic [2:0] strap_cnt_q;
  logic strap_q;
  logic [3:0] f [12];
  logic [11:0] alt_v, alt_en, alt_od, ana;
  logic [3:0] t2_at_b;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Privileged writes only
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pa_lo_q <= afpm_pkg::CFG_RESET;
      pa_hi_q <= afpm_pkg::CFG_RESET;
      pb_lo_q <= afpm_pkg::CFG_RESET;
      pb_hi_q <= afpm_pkg::CFG_RESET;
      pc_hi_q <= afpm_pkg::CFG_RESET;
      dbg_q <= 8'h00;
      remap_q <= afpm_pkg::REMAP_RESET;
    end else if (cfg_wr_in.wr && cfg_wr_in.privileged) begin
      case (cfg_wr_in.sel)
        afpm_pkg::SEL_PA_LO: pa_lo_q <= cfg_wr_in.data;
        afpm_pkg::SEL_PA_HI: pa_hi_q <= cfg_wr_in.data;
        afpm_pkg::SEL_PB_LO: pb_lo_q <= cfg_wr_in.data;
        afpm_pkg::SEL_PB_HI: pb_hi_q <= cfg_wr_in.data;
        afpm_pkg::SEL_PC_HI: pc_hi_q <= cfg_wr_in.data;
        afpm_pkg::SEL_DBG: dbg_q <= cfg_wr_in.data[7:0];
        afpm_pkg::SEL_REMAP: remap_q <= cfg_wr_in.data[7:0];
        default: ;
      endcase
    end
  end

  // Read port, refusal flag
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_rd_data_out <= 16'h0000;
      cfg_refused_out <= 1'b0;
    end else begin
      cfg_refused_out <= cfg_wr_in.wr && !cfg_wr_in.privileged;
      if (!cfg_wr_in.privileged) begin
        cfg_rd_data_out <= 16'h0000;
      end else begin
        case (cfg_rd_sel_in)
          afpm_pkg::SEL_PA_LO: cfg_rd_data_out <= pa_lo_q;
          afpm_pkg::SEL_PA_HI: cfg_rd_data_out <= pa_hi_q;
          afpm_pkg::SEL_PB_LO: cfg_rd_data_out <= pb_lo_q;
          afpm_pkg::SEL_PB_HI: cfg_rd_data_out <= pb_hi_q;
          afpm_pkg::SEL_PC_HI: cfg_rd_data_out <= pc_hi_q;
          afpm_pkg::SEL_DBG: cfg_rd_data_out <= {8'h00, dbg_q};
          // Write-only: reset value
          afpm_pkg::SEL_REMAP: cfg_rd_data_out <= {8'h00, afpm_pkg::REMAP_RESET};
          default: cfg_rd_data_out <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers and boot strap
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_s1_q <= 12'h000;
      pad_s2_q <= 12'h000;
    end else begin
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // Strap tracked, then frozen
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_cnt_q <= 3'h0;
      strap_q <= 1'b1;
    end else if (strap_cnt_q != 3'(STRAP_CYCLES)) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      strap_q <= pad_s2_q[5];
    end
  end

  // ----------------------------------------------------------------
  // Function selection per pad
  // ----------------------------------------------------------------
  always_comb begin
    f[0] = fld(pa_lo_q, afpm_pkg::F0);
    f[1] = fld(pa_lo_q, afpm_pkg::F1);
    f[2] = fld(pa_lo_q, afpm_pkg::F2);
    f[3] = fld(pa_lo_q, afpm_pkg::F3);
    f[4] = fld(pa_hi_q, afpm_pkg::F0);
    f[5] = fld(pa_hi_q, afpm_pkg::F1);
    f[6] = fld(pa_hi_q, afpm_pkg::F3);
    f[7] = fld(pb_lo_q, afpm_pkg::F3);
    f[8] = fld(pb_hi_q, afpm_pkg::F0);
    f[9] = fld(pc_hi_q, afpm_pkg::F1);
    f[10] = fld(pc_hi_q, afpm_pkg::F2);
    f[11] = fld(pc_hi_q, afpm_pkg::F3);
  end

  // Alternate sources per pad
  always_comb begin
    logic s2m, s1m;
    logic [3:0] t2a;
    s2m = serial2_spi_config_in[afpm_pkg::SPI_MASTER];
    s1m = serial1_spi_config_in[afpm_pkg::SPI_MASTER];
    t2_at_b = remap_q[afpm_pkg::REMAP_CH4:afpm_pkg::REMAP_CH1];
    t2a = timer2_channel_output_enables_in & ~t2_at_b;
    alt_v = 12'h000;
    alt_en = 12'h000;
    alt_od = 12'h000;
    // PA0: timer 2 ch1 or serial 2 data out
    if (t2a[0]) begin
      alt_v[0] = timer2_out_in[0]; alt_en[0] = 1'b1;
    end else if (serial2_function_select_in == afpm_pkg::AFPM_SC_SPI && s2m) begin
      alt_v[0] = serial2_master_out_slave_in_in; alt_en[0] = 1'b1;
    end
    // PA1: timer 2 ch3, I2C data or slave data out
    if (t2a[2]) begin
      alt_v[1] = timer2_out_in[2]; alt_en[1] = 1'b1;
    end else if (serial2_function_select_in == afpm_pkg::AFPM_SC_I2C) begin
      alt_v[1] = serial2_i2c_data_in; alt_en[1] = 1'b1; alt_od[1] = 1'b1;
    end else if (serial2_function_select_in == afpm_pkg::AFPM_SC_SPI && !s2m) begin
      alt_v[1] = serial2_master_in_slave_out_in; alt_en[1] = 1'b1;
    end
    // PA2: timer 2 ch4, I2C clock or master clock
    if (t2a[3]) begin
      alt_v[2] = timer2_out_in[3]; alt_en[2] = 1'b1;
    end else if (serial2_function_select_in == afpm_pkg::AFPM_SC_I2C) begin
      alt_v[2] = serial2_i2c_clock_in; alt_en[2] = 1'b1; alt_od[2] = 1'b1;
    end else if (serial2_function_select_in == afpm_pkg::AFPM_SC_SPI && s2m) begin
      alt_v[2] = serial2_spi_clock_in; alt_en[2] = 1'b1;
    end
    // PA3: timer 2 ch2 or core trace clock
    if (t2a[1]) begin
      alt_v[3] = timer2_out_in[1]; alt_en[3] = 1'b1;
    end else if (trace_enable_in) begin
      alt_v[3] = cpu_trace_clock_in; alt_en[3] = 1'b1;
    end
    // PA4/PA5: packet trace or four-wire core trace
    if (!trace_enable_in) begin
      alt_v[4] = packet_trace_frame_in; alt_en[4] = 1'b1;
      alt_v[5] = packet_trace_serial_data_in; alt_en[5] = 1'b1;
    end else if (trace_four_wire_in) begin
      alt_v[4] = cpu_trace_bit_two_in; alt_en[4] = 1'b1;
      alt_v[5] = cpu_trace_bit_three_in; alt_en[5] = 1'b1;
    end
    // PA7: timer 1 ch4 once regulator enable released
    alt_v[6] = timer1_channel_four_in;
    alt_en[6] = timer1_channel_output_enables_in;
    // PB3: remapped timer 2 ch3 or serial 1 master clock
    if (t2_at_b[2] && timer2_channel_output_enables_in[2]) begin
      alt_v[7] = timer2_out_in[2]; alt_en[7] = 1'b1;
    end else if (serial1_function_select_in == afpm_pkg::AFPM_SC_SPI && s1m) begin
      alt_v[7] = serial1_spi_clock_in; alt_en[7] = 1'b1;
    end
    // PB4: remapped timer 2 ch4 or UART request-to-send
    if (t2_at_b[3] && timer2_channel_output_enables_in[3]) begin
      alt_v[8] = timer2_out_in[3]; alt_en[8] = 1'b1;
    end else if (serial1_function_select_in == afpm_pkg::AFPM_SC_UART
                 && serial1_uart_config_in[afpm_pkg::UART_FLOW]) begin
      alt_v[8] = serial1_rts_in; alt_en[8] = 1'b1;
    end
    // PC5/PC6: transmit indicator, true and inverted
    alt_v[9] = radio_tx_mode_in; alt_en[9] = 1'b1;
    alt_v[10] = !radio_tx_mode_in; alt_en[10] = 1'b1;
    for (int i = 0; i < 12; i++) begin
      ana[i] = is_ana(f[i]);
    end
    ana[0] = 1'b0; ana[1] = 1'b0; ana[2] = 1'b0; ana[3] = 1'b0; // No analog on PA0-3
    ana[6] = 1'b0; ana[7] = 1'b0; ana[8] = 1'b0; ana[9] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_out <= 12'h000;
      pad_oe_n_out <= 12'hFFF;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (ana[i]) begin
          pad_out[i] <= 1'b0;
          pad_oe_n_out[i] <= 1'b1;
        end else if (is_alt(f[i]) && alt_en[i]) begin
          pad_out[i] <= (alt_od[i] || f[i] == afpm_pkg::FN_ALT_OD) ? 1'b0 : alt_v[i];
          pad_oe_n_out[i] <= (alt_od[i] || f[i] == afpm_pkg::FN_ALT_OD)
                             ? alt_v[i] : 1'b0;
        end else if (is_alt(f[i])) begin
          pad_out[i] <= 1'b0;
          pad_oe_n_out[i] <= 1'b1;
        end else begin
          pad_out[i] <= gpio_data_in[i];
          pad_oe_n_out[i] <= !gpio_dir_in[i];
        end
      end
      // Regulator enable owns PA7 until debug bit
      if (!dbg_q[afpm_pkg::DBG_REG_DISABLE]) begin
        pad_out[6] <= 1'b0;
        pad_oe_n_out[6] <= reg_enable_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Inputs towards peripherals
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gpio_read_out <= 12'h000;
      timer2_cap_out <= 4'h0;
      timer1_channel_four_cap_out <= 1'b0;
      serial1_spi_clock_out <= 1'b0;
      serial1_slave_select_out <= 1'b1;
      serial1_cts_out <= 1'b0;
      serial2_data_rx_out <= 1'b0;
      serial2_spi_clock_out <= 1'b0;
      serial2_slave_select_out <= 1'b1;
      serial2_i2c_data_out <= 1'b1;
      serial2_i2c_clock_out <= 1'b1;
      bootloader_strap_n_out <= 1'b1;
      lowfreq_digital_clock_out <= 1'b0;
      lowfreq_crystal_a_out <= 1'b0;
      lowfreq_crystal_b_out <= 1'b0;
      analog_input_four_out <= 1'b0;
      analog_input_five_out <= 1'b0;
    end else begin
      gpio_read_out <= pad_s2_q & ~ana;
      timer2_cap_out[0] <= pad_s2_q[0];
      timer2_cap_out[1] <= pad_s2_q[3];
      timer2_cap_out[2] <= t2_at_b[2] ? pad_s2_q[7] : pad_s2_q[1];
      timer2_cap_out[3] <= t2_at_b[3] ? pad_s2_q[8] : pad_s2_q[2];
      timer1_channel_four_cap_out <= pad_s2_q[6];
      serial1_spi_clock_out <= pad_s2_q[7];
      serial1_slave_select_out <= pad_s2_q[8];
      serial1_cts_out <= serial1_uart_config_in[afpm_pkg::UART_FLOW] && pad_s2_q[7];
      // Master reads PA1, slave PA0
      serial2_data_rx_out <= serial2_spi_config_in[afpm_pkg::SPI_MASTER]
                             ? pad_s2_q[1] : pad_s2_q[0];
      serial2_spi_clock_out <= pad_s2_q[2];
      serial2_slave_select_out <= pad_s2_q[3];
      serial2_i2c_data_out <= pad_s2_q[1];
      serial2_i2c_clock_out <= pad_s2_q[2];
      bootloader_strap_n_out <= strap_q;
      lowfreq_digital_clock_out <= !ana[11] && pad_s2_q[11];
      lowfreq_crystal_a_out <= ana[11];
      lowfreq_crystal_b_out <= ana[10];
      analog_input_four_out <= ana[4];
      analog_input_five_out <= ana[5];
    end
  end
endmodule : afpm_top

// ### testbench/afpm_top_sva.sv
/*
 Checker on the pin mux ports.
 Assumes a bind to afpm_top.
*/
`timescale 1ns/100ps
module afpm_top_sva #(
  parameter int STRAP_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire afpm_pkg::afpm_cfg_wr_t cfg_wr_in,
  input wire logic [2:0] cfg_rd_sel_in,
  input wire logic [15:0] cfg_rd_data_out,
  input wire logic cfg_refused_out,
  input wire logic radio_tx_mode_in,
  input wire logic reg_enable_in,
  input wire logic bootloader_strap_n_out,
  input wire logic lowfreq_crystal_a_out,
  input wire logic [11:0] pad_out,
  input wire logic [11:0] pad_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic wr_ok;
  logic [15:0] pc_hi_q;
  logic dbg_q;
  logic [3:0] cnt_q;
  assign wr_ok = cfg_wr_in.wr && cfg_wr_in.privileged;
  // Shadow registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_hi_q <= afpm_pkg::CFG_RESET;
      dbg_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
      if (wr_ok && cfg_wr_in.sel == afpm_pkg::SEL_PC_HI) pc_hi_q <= cfg_wr_in.data;
      if (wr_ok && cfg_wr_in.sel == afpm_pkg::SEL_DBG) dbg_q <= cfg_wr_in.data[4];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_refuse;
    (cfg_wr_in.wr && !cfg_wr_in.privileged) |=> cfg_refused_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write not refused");
  property p_rd_unpriv;
    !cfg_wr_in.privileged |=> cfg_rd_data_out == 16'h0000;
  endproperty
  a_rd_unpriv: assert property (p_rd_unpriv) else $error("read not blanked");
  property p_remap_wo;
    cfg_rd_sel_in == afpm_pkg::SEL_REMAP |=> cfg_rd_data_out == 16'h0000;
  endproperty
  a_remap_wo: assert property (p_remap_wo) else $error("remap readback wrong");
  property p_tx_ind;
    pc_hi_q[7:4] == afpm_pkg::FN_ALT_PP && !wr_ok
      |=> pad_out[9] == $past(radio_tx_mode_in) && !pad_oe_n_out[9];
  endproperty
  a_tx_ind: assert property (p_tx_ind) else $error("indicator wrong on pc5");
  property p_tx_inv;
    pc_hi_q[11:8] == afpm_pkg::FN_ALT_PP && !wr_ok
      |=> pad_out[10] == !$past(radio_tx_mode_in) && !pad_oe_n_out[10];
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("pc6 indicator wrong");
  property p_crystal;
    pc_hi_q[15:12] == afpm_pkg::FN_ANALOG && !wr_ok |=> lowfreq_crystal_a_out && pad_oe_n_out[11];
  endproperty
  a_crystal: assert property (p_crystal) else $error("pc7 not handed to crystal");
  property p_regen;
    !dbg_q && !wr_ok |=> pad_oe_n_out[6] == $past(reg_enable_in);
  endproperty
  a_regen: assert property (p_regen) else $error("pa7 regulator wrong");
  property p_strap;
    (int'(cnt_q) > STRAP_CYCLES + 3) |-> $stable(bootloader_strap_n_out);
  endproperty
  a_strap: assert property (p_strap) else $error("strap moved");
  // Scenarios
  c_refuse: cover property (cfg_wr_in.wr && !cfg_wr_in.privileged);
  c_tx: cover property (pc_hi_q[7:4] == afpm_pkg::FN_ALT_PP && radio_tx_mode_in);
  c_xtal: cover property (pc_hi_q[15:12] == afpm_pkg::FN_ANALOG);
endmodule : afpm_top_sva

bind afpm_top afpm_top_sva #(.STRAP_CYCLES(STRAP_CYCLES)) u_sva (.*);

// ### testbench/afpm_board.sv
/*
 Board model: mux, outside driver, pull-up.
 Assumes pad order PA0-5, PA7, PB3-4, PC5-7.
*/
`timescale 1ns/100ps
module afpm_board (
  input wire logic [11:0] pad_out_in,
  input wire logic [11:0] pad_oe_n_in,
  input wire logic [11:0] ext_en_in,
  input wire logic [11:0] ext_val_in,
  output logic [11:0] pad_level_out
);
  // Device, outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (!pad_oe_n_in[i]) pad_level_out[i] = pad_out_in[i];
      else if (ext_en_in[i]) pad_level_out[i] = ext_val_in[i];
      else pad_level_out[i] = 1'b1;
    end
  end
endmodule : afpm_board

// ### testbench/alternate_function_pin_mux_tb.sv
/*
 Pin mux bench, one task per function.
 Assumes design, board and checker compiled.
*/
`timescale 1ns/100ps
module alternate_function_pin_mux_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in, nrst_in, cfg_refused_out, timer1_channel_output_enables_in;
  afpm_pkg::afpm_cfg_wr_t cfg_wr_in;
  afpm_pkg::afpm_sc_mode_t serial1_function_select_in, serial2_function_select_in;
  logic [2:0] cfg_rd_sel_in;
  logic [15:0] cfg_rd_data_out;
  logic [3:0] timer2_channel_output_enables_in, timer2_out_in, timer2_cap_out;
  logic timer1_channel_four_in, timer1_channel_four_cap_out, serial1_spi_clock_in;
  logic [7:0] serial1_spi_config_in, serial2_spi_config_in, serial1_uart_config_in;
  logic serial1_spi_clock_out, serial1_slave_select_out, serial1_rts_in, serial1_cts_out;
  logic serial2_master_out_slave_in_in, serial2_master_in_slave_out_in, serial2_spi_clock_in;
  logic serial2_i2c_data_in, serial2_i2c_clock_in, serial2_data_rx_out, serial2_spi_clock_out;
  logic serial2_slave_select_out, serial2_i2c_data_out, serial2_i2c_clock_out;
  logic radio_tx_mode_in, reg_enable_in, packet_trace_frame_in, packet_trace_serial_data_in;
  logic trace_enable_in, trace_four_wire_in, cpu_trace_clock_in, cpu_trace_bit_two_in;
  logic cpu_trace_bit_three_in, bootloader_strap_n_out, lowfreq_digital_clock_out;
  logic lowfreq_crystal_a_out, lowfreq_crystal_b_out, analog_input_four_out, analog_input_five_out;
  logic [11:0] gpio_data_in, gpio_dir_in, gpio_read_out, pad_in, pad_out, pad_oe_n_out;
  logic [11:0] ext_en, ext_val;
  int failures, samples_checked;
  afpm_top #(.STRAP_CYCLES(4)) u_dut (.*);
  afpm_board u_board (.pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n_out), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pad_level_out(pad_in));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic settle;
    repeat (4) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic wr(input logic [2:0] s, input logic [15:0] d, input logic p);
    @(posedge clk_in);
    cfg_wr_in <= {1'b1, p, s, d};
    @(posedge clk_in);
    cfg_wr_in <= {1'b0, 1'b1, s, d};
    #1;
    chk("refused", cfg_refused_out, !p);
  endtask : wr
  task automatic rd(input logic [2:0] s, input logic p, output logic [15:0] d);
    @(posedge clk_in);
    cfg_rd_sel_in <= s;
    cfg_wr_in.privileged <= p;
    repeat (2) @(posedge clk_in);
    #1 d = cfg_rd_data_out;
  endtask : rd
  task automatic summarize;
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg;
    logic [15:0] d;
    repeat (8) @(posedge clk_in);
    ext_val[5] <= 1'b1;
    settle;
    chk("strap", bootloader_strap_n_out, 1'b0);
    rd(afpm_pkg::SEL_PA_LO, 1'b1, d);
    chk("pa_lo_rst", d, afpm_pkg::CFG_RESET);
    wr(afpm_pkg::SEL_PA_LO, 16'h9D41, 1'b1);
    wr(afpm_pkg::SEL_PA_LO, 16'h0000, 1'b0);
    rd(afpm_pkg::SEL_PA_LO, 1'b1, d);
    chk("pa_lo", d, 16'h9D41);
    rd(afpm_pkg::SEL_PA_LO, 1'b0, d);
    chk("pa_lo_unpriv", d, 16'h0000);
    wr(afpm_pkg::SEL_REMAP, 16'h00C0, 1'b1);
    rd(afpm_pkg::SEL_REMAP, 1'b1, d);
    chk("remap_rd", d, 16'h0000);
  endtask : t_cfg
  task automatic t_radio;
    wr(afpm_pkg::SEL_PC_HI, 16'h4994, 1'b1);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_in);
      radio_tx_mode_in <= v[0];
      settle;
      chk("tx_ind", {pad_oe_n_out[10:9], pad_out[10:9]}, {2'b00, !v[0], v[0]});
    end
    wr(afpm_pkg::SEL_PC_HI, 16'h0014, 1'b1);
    @(posedge clk_in);
    gpio_dir_in <= 12'h200;
    settle;
    chk("pc5_gpio", {pad_oe_n_out[9], pad_out[9]}, 2'b00);
    chk("xtal", {lowfreq_crystal_a_out, lowfreq_crystal_b_out, pad_oe_n_out[11:10]}, 4'hF);
    wr(afpm_pkg::SEL_PC_HI, 16'h4444, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      ext_en[11] <= 1'b1;
      ext_val[11] <= k[0];
      settle;
      chk("lf_clk", lowfreq_digital_clock_out, k[0]);
    end
  endtask : t_radio
  task automatic t_timer;
    logic [3:0] v;
    wr(afpm_pkg::SEL_PA_LO, 16'h9999, 1'b1);
    wr(afpm_pkg::SEL_PB_LO, 16'h9444, 1'b1);
    wr(afpm_pkg::SEL_PB_HI, 16'h4449, 1'b1);
    @(posedge clk_in);
    timer2_channel_output_enables_in <= 4'hF;
    serial2_function_select_in <= afpm_pkg::AFPM_SC_I2C;
    for (int r = 0; r < 2; r++) begin
      wr(afpm_pkg::SEL_REMAP, r ? 16'h00C0 : 16'h0000, 1'b1);
      for (int k = 0; k < 2; k++) begin
        v = k ? 4'hA : 4'h5;
        @(posedge clk_in);
        timer2_out_in <= v;
        serial2_i2c_data_in <= k[0];
        settle;
        if (r == 0) chk("t2_pa", pad_out[3:0], {v[1], v[3], v[2], v[0]});
        else chk("t2_pb", {pad_oe_n_out[8:7], pad_out[8:7], pad_oe_n_out[1]}, {2'b00, v[3], v[2], k[0]});
      end
    end
    wr(afpm_pkg::SEL_PB_LO, 16'h4444, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      ext_en[7] <= 1'b1;
      ext_val[7] <= k[0];
      settle;
      chk("t2_cap", timer2_cap_out[2], k[0]);
    end
  endtask : t_timer
  task automatic t_serial;
    wr(afpm_pkg::SEL_PA_LO, 16'h4449, 1'b1);
    @(posedge clk_in);
    timer2_channel_output_enables_in <= 4'h0;
    serial2_function_select_in <= afpm_pkg::AFPM_SC_SPI;
    serial2_spi_config_in <= 8'h10;
    serial2_master_out_slave_in_in <= 1'b1;
    serial1_function_select_in <= afpm_pkg::AFPM_SC_UART;
    serial1_uart_config_in <= 8'h20;
    serial1_rts_in <= 1'b1;
    ext_val[7] <= 1'b0;
    settle;
    chk("spi_m", {pad_oe_n_out[0], pad_out[0], pad_out[8], serial1_cts_out}, 4'h6);
    @(posedge clk_in);
    serial2_spi_config_in <= 8'h00;
    ext_en[3:0] <= 4'hF;
    ext_val[3:0] <= 4'h0;
    settle;
    chk("spi_s", {pad_oe_n_out[0], serial2_data_rx_out, serial2_slave_select_out,
      serial2_spi_clock_out, serial2_i2c_data_out, serial2_i2c_clock_out, serial1_spi_clock_out,
      serial1_slave_select_out, timer1_channel_four_cap_out, timer2_cap_out}, 13'h1028);
  endtask : t_serial
  task automatic t_pa7;
    wr(afpm_pkg::SEL_PA_HI, 16'h9444, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      reg_enable_in <= k[0];
      timer1_channel_output_enables_in <= 1'b1;
      timer1_channel_four_in <= 1'b1;
      settle;
      chk("regen", pad_oe_n_out[6], k[0]);
    end
    wr(afpm_pkg::SEL_DBG, 16'h0010, 1'b1);
    settle;
    chk("t1c4", {pad_oe_n_out[6], pad_out[6]}, 2'b01);
    @(posedge clk_in);
    timer1_channel_output_enables_in <= 1'b0;
    settle;
    chk("t1c4_off", pad_oe_n_out[6], 1'b1);
  endtask : t_pa7
  task automatic t_trace;
    wr(afpm_pkg::SEL_PA_HI, 16'h9499, 1'b1);
    wr(afpm_pkg::SEL_PA_LO, 16'h9444, 1'b1);
    @(posedge clk_in);
    {packet_trace_frame_in, cpu_trace_bit_three_in, cpu_trace_clock_in} <= 3'h7;
    trace_four_wire_in <= 1'b1;
    timer2_out_in <= 4'h0;
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_in);
      trace_enable_in <= t[0];
      settle;
      chk("trace", {pad_out[5:4], pad_oe_n_out[3]}, t ? 3'h4 : 3'h3);
    end
    chk("trace_clk", pad_out[3], 1'b1);
    @(posedge clk_in);
    timer2_channel_output_enables_in <= 4'h2;
    settle;
    chk("trace_clk_off", {pad_oe_n_out[3], pad_out[3]}, 2'b00);
    wr(afpm_pkg::SEL_PA_HI, 16'h9400, 1'b1);
    settle;
    chk("analog", {analog_input_five_out, analog_input_four_out, pad_oe_n_out[5:4],
      gpio_read_out[5:4]}, 6'h3C);
  endtask : t_trace
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    summarize;
  end
  // Reset, then all scenarios
  initial begin
    {nrst_in, cfg_rd_sel_in, timer2_channel_output_enables_in, timer1_channel_output_enables_in,
      timer2_out_in, timer1_channel_four_in, serial1_spi_config_in, serial2_spi_config_in,
      serial1_uart_config_in, serial1_spi_clock_in, serial1_rts_in, serial2_master_out_slave_in_in,
      serial2_master_in_slave_out_in, serial2_spi_clock_in, serial2_i2c_data_in,
      serial2_i2c_clock_in, radio_tx_mode_in, reg_enable_in, packet_trace_frame_in,
      packet_trace_serial_data_in, trace_enable_in, trace_four_wire_in, cpu_trace_clock_in,
      cpu_trace_bit_two_in, cpu_trace_bit_three_in, gpio_data_in, gpio_dir_in} = '0;
    cfg_wr_in = {1'b0, 1'b1, 3'h0, 16'h0000};
    serial1_function_select_in = afpm_pkg::AFPM_SC_OFF;
    serial2_function_select_in = afpm_pkg::AFPM_SC_OFF;
    ext_en = 12'h020;
    ext_val = 12'h000;
    failures = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_cfg;
    t_radio;
    t_timer;
    t_serial;
    t_pa7;
    t_trace;
    summarize;
  end
endmodule : alternate_function_pin_mux_tb
